// ### core/mci_defines.vh
/*
  Constants of the command interpreter: register byte offsets, parameter
  slots, defaults, limits, command codes and timing.
  Assumes inclusion by bare name from the core design files.
*/
`ifndef MCI_DEFINES_VH
`define MCI_DEFINES_VH

// ----------------------------------------
// Register byte offsets (index * 4)
// ----------------------------------------
`define MCI_A_CMD      8'h00
`define MCI_A_PAR0     8'h04
`define MCI_A_PARN     8'h20
`define MCI_A_DEVTYPE  8'h24
`define MCI_A_UIDHI    8'h28
`define MCI_A_UIDLO    8'h2C
`define MCI_A_MAXPAY   8'h30
`define MCI_A_OPSLEEP  8'h34
`define MCI_A_OPWAKE   8'h38
`define MCI_A_SLPSTAT  8'h3C
`define MCI_A_MISSED   8'h40
`define MCI_A_VERDATE  8'h44
`define MCI_A_VERTIME  8'h48

// ----------------------------------------
// Parameter slots
// ----------------------------------------
`define MCI_NPAR       8
`define MCI_P_DESTHI   3'h0
`define MCI_P_DESTLO   3'h1
`define MCI_P_CHAN     3'h2
`define MCI_P_SRCEP    3'h3
`define MCI_P_DSTEP    3'h4
`define MCI_P_CLUSTER  3'h5
`define MCI_P_PROTO    3'h6
`define MCI_P_SLPOPT   3'h7

// ----------------------------------------
// Defaults and limits
// ----------------------------------------
`define MCI_DEF_DESTHI  32'h0000_0000
`define MCI_DEF_DESTLO  32'h0000_FFFF
`define MCI_DEF_CHAN    32'h0000_0000
`define MCI_DEF_EP      32'h0000_00A0
`define MCI_DEF_CLUSTER 32'h0000_0011
`define MCI_DEF_PROTO   32'h0000_0000
`define MCI_DEF_SLPOPT  32'h0000_0000
`define MCI_MAX_ANY     32'hFFFF_FFFF
`define MCI_MAX_CHAN    32'h0000_0007
`define MCI_MAX_CHAN_I  32'h0000_0003
`define MCI_MAX_BYTE    32'h0000_00FF
`define MCI_MAX_HALF    32'h0000_FFFF
`define MCI_MAX_PROTO   32'h0000_0002
`define MCI_MAX_SLPOPT  32'h0000_0001
`define MCI_PROTO_FRAMED 32'h0000_0001
`define MCI_SOPT_NOTIFY 0

// ----------------------------------------
// Commands, status bits, frame codes
// ----------------------------------------
`define MCI_C_PERSIST  8'h01
`define MCI_C_FACTORY  8'h02
`define MCI_C_RESTART  8'h03
`define MCI_C_COMMIT   8'h04
`define MCI_C_BUILD    8'h05
`define MCI_C_VERSION  8'h06
`define MCI_S_OK       0
`define MCI_S_ERR      1
`define MCI_S_BUSY     2
`define MCI_S_NVVALID  3
`define MCI_FR_WAKE    8'h0B
`define MCI_FR_SLEEP   8'h0C

// ----------------------------------------
// Payload and timing
// ----------------------------------------
`define MCI_PAY_BASE   16'h0100
`define MCI_PAY_BCAST  16'h0008
`define MCI_PAY_FRAMED 16'h0002
`define MCI_RESTART_MS 100
`define MCI_CLK_KHZ    200000

`endif

// ### core/mci_missed_sync.v
/*
  Counter of sleep cycles since the last received sync message.
  Assumes one-cycle pulses from the sleep scheduler, synchronous to sys_clk.
*/
`timescale 1ns/10ps
module mci_missed_sync (
  input wire sys_clk,
  input wire arst_n,
  input wire soft_clr,
  input wire cycle_done,
  input wire sync_rx,
  output reg [31:0] count_reg
);
  reg [31:0] count_next;

  always @* begin
    count_next = count_reg;
    if (sync_rx || soft_clr) begin
      count_next = 32'h0000_0000;
    end else if (cycle_done && count_reg != 32'hFFFF_FFFF) begin
      // Saturates rather than wrapping, so a long outage never reads as fresh
      count_next = count_reg + 32'h0000_0001;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 32'h0000_0000;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule // mci_missed_sync

// ### core/mci_delay_timer.v
/*
  One-shot delay: a start pulse arms it, done pulses LEN cycles later.
  Assumes LEN of at least two.
*/
`timescale 1ns/10ps
module mci_delay_timer #(
  parameter LEN = 20000000
) (
  input wire sys_clk,
  input wire arst_n,
  input wire start,
  output reg busy_reg,
  output reg done_reg
);
  reg [31:0] cnt_reg;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= LEN - 1;
      end else if (busy_reg) begin
        if (cnt_reg == 32'h0000_0001) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        cnt_reg <= cnt_reg - 32'h0000_0001;
      end
    end
  end
endmodule // mci_delay_timer

// ### core/mci_top.v
/*
  Command interpreter of a wireless module: addressing parameters, special
  commands and sleep diagnostics, reached over a classic Wishbone slave.
  Assumes sleep scheduler events and timing arrive synchronous to sys_clk.
*/
// Functional notes
// - Report operational sleep and wake periods
// - Sleep status includes coordinator flag
// - Count cycles since sync, clear on sync
// - Notify wake and sleep in framed mode
// - Persist copies parameters to retained storage
// - Factory restore loads documented defaults
// - Restart: OK now, reset 100 ms later
// - Commit applies pending settings immediately
// - Build restore loads built-in defaults, same values as factory set
// - Long version gives build date, time
// - 64-bit destination from two halves
// - Device type read only, writes refused
// - Unique address halves read only
// - Channel limited per variant, default zero
// - Source endpoint drives every transmission
// - Target endpoint drives every transmission
// - Cluster ident, default 0x11, every transmission
// - Max payload recomputed from settings
// - Protocol value one means framed
`timescale 1ns/10ps
`include "mci_defines.vh"
module mci_top #(
  parameter INTL_VARIANT = 0,
  parameter RESTART_CYCLES = `MCI_RESTART_MS * `MCI_CLK_KHZ,
  parameter [31:0] DEVICE_TYPE = 32'h0000_0A5C, // Arbitrary value
  parameter [31:0] UID_UPPER = 32'h0012_3456,   // Arbitrary value
  parameter [31:0] UID_LOWER = 32'h789A_BCDE,   // Arbitrary value
  parameter [31:0] BUILD_DATE = 32'h0000_0101,  // Arbitrary value
  parameter [31:0] BUILD_TIME = 32'h0000_1200   // Arbitrary value
) (
  input wire sys_clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  input wire [31:0] op_sleep_period,
  input wire [31:0] op_wake_period,
  input wire [7:0] sleep_status_bits,
  input wire is_sleep_coord,
  input wire sleep_cycle_done,
  input wire sync_rx,
  input wire woke_evt,
  input wire sleep_evt,
  output reg [63:0] tx_dest_addr,
  output reg [7:0] tx_source_endpoint,
  output reg [7:0] tx_target_endpoint,
  output reg [15:0] tx_cluster_ident,
  output reg [2:0] channel_select,
  output reg framed_host_protocol,
  output reg status_frame_valid,
  output reg [7:0] status_frame_code,
  output reg module_reset
);

  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------
  function [31:0] par_default;
    input [2:0] idx;
    input build;
    begin
      case (idx)
        `MCI_P_DESTHI: par_default = `MCI_DEF_DESTHI;
        `MCI_P_DESTLO: par_default = `MCI_DEF_DESTLO;
        `MCI_P_CHAN: par_default = `MCI_DEF_CHAN;
        `MCI_P_SRCEP: par_default = `MCI_DEF_EP;
        `MCI_P_DSTEP: par_default = `MCI_DEF_EP;
        `MCI_P_CLUSTER: par_default = `MCI_DEF_CLUSTER;
        `MCI_P_PROTO: par_default = `MCI_DEF_PROTO;
        default: par_default = `MCI_DEF_SLPOPT;
      endcase
      // Build image defaults equal the factory set here; kept as a separate path
      if (build) begin
        par_default = par_default;
      end
    end
  endfunction

  function [31:0] par_max;
    input [2:0] idx;
    begin
      case (idx)
        `MCI_P_CHAN: par_max = (INTL_VARIANT != 0) ? `MCI_MAX_CHAN_I : `MCI_MAX_CHAN;
        `MCI_P_SRCEP: par_max = `MCI_MAX_BYTE;
        `MCI_P_DSTEP: par_max = `MCI_MAX_BYTE;
        `MCI_P_CLUSTER: par_max = `MCI_MAX_HALF;
        `MCI_P_PROTO: par_max = `MCI_MAX_PROTO;
        `MCI_P_SLPOPT: par_max = `MCI_MAX_SLPOPT;
        default: par_max = `MCI_MAX_ANY;
      endcase
    end
  endfunction

  function [31:0] merge_sel;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      merge_sel = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge_sel[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] pend_reg [0:`MCI_NPAR-1];
  reg [31:0] act_reg [0:`MCI_NPAR-1];
  // Retained storage: cleared only by power-on reset, not by soft restart
  reg [31:0] nv_reg [0:`MCI_NPAR-1];
  reg nv_valid_reg;
  reg ok_reg;
  reg err_reg;
  reg [31:0] ver_date_reg;
  reg [31:0] ver_time_reg;
  reg [15:0] max_pay_reg;
  // Pulse that reloads parameters after a restart
  reg soft_rst_reg;
  wire [31:0] missed_count;
  wire restart_busy;
  wire restart_done;

  // A pending answer blocks a second take
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire is_par = (wb_adr_i >= `MCI_A_PAR0) && (wb_adr_i <= `MCI_A_PARN)
    && (wb_adr_i[1:0] == 2'b00);
  wire is_cmd = (wb_adr_i == `MCI_A_CMD);
  wire is_ro = (wb_adr_i >= `MCI_A_DEVTYPE) && (wb_adr_i <= `MCI_A_VERTIME)
    && (wb_adr_i[1:0] == 2'b00);
  wire [7:0] pidx_full = (wb_adr_i - `MCI_A_PAR0) >> 2;
  wire [31:0] wr_val = merge_sel(pend_reg[pidx_full[2:0]], wb_dat_i, wb_sel_i);
  wire par_ok = wr_val <= par_max(pidx_full[2:0]);
  wire [7:0] cmd = wb_dat_i[7:0];
  wire cmd_known = (cmd >= `MCI_C_PERSIST) && (cmd <= `MCI_C_VERSION);
  wire wr = req && wb_we_i;
  wire cmd_go = wr && is_cmd && cmd_known && !restart_busy;
  // Refused writes: bad range, read-only words, unknown or badly timed commands
  wire wr_bad = wr && ((is_par && !par_ok) || is_ro
    || (is_cmd && !(cmd_known && !restart_busy)));

  // ----------------------------------------
  // Wishbone answer
  // ----------------------------------------
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wr_bad;
      wb_err_o <= req && wr_bad;
      if (req && !wb_we_i) begin
        if (is_par) begin
          wb_dat_o <= pend_reg[pidx_full[2:0]];
        end else begin
          case (wb_adr_i)
            `MCI_A_CMD: wb_dat_o <= {28'h000_0000, nv_valid_reg, restart_busy, err_reg, ok_reg};
            `MCI_A_DEVTYPE: wb_dat_o <= DEVICE_TYPE;
            `MCI_A_UIDHI: wb_dat_o <= UID_UPPER;
            `MCI_A_UIDLO: wb_dat_o <= UID_LOWER;
            `MCI_A_MAXPAY: wb_dat_o <= {16'h0000, max_pay_reg};
            `MCI_A_OPSLEEP: wb_dat_o <= op_sleep_period;
            `MCI_A_OPWAKE: wb_dat_o <= op_wake_period;
            `MCI_A_SLPSTAT: wb_dat_o <= {23'h00_0000, is_sleep_coord, sleep_status_bits};
            `MCI_A_MISSED: wb_dat_o <= missed_count;
            `MCI_A_VERDATE: wb_dat_o <= ver_date_reg;
            `MCI_A_VERTIME: wb_dat_o <= ver_time_reg;
            // Unmapped reads answer zero
            default: wb_dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Parameter store and commands
  // ----------------------------------------
  integer i;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < `MCI_NPAR; i = i + 1) begin
        pend_reg[i] <= par_default(i[2:0], 1'b0);
        act_reg[i] <= par_default(i[2:0], 1'b0);
        nv_reg[i] <= 32'h0000_0000;
      end
      nv_valid_reg <= 1'b0;
      ok_reg <= 1'b0;
      err_reg <= 1'b0;
      ver_date_reg <= 32'h0000_0000;
      ver_time_reg <= 32'h0000_0000;
    end else if (soft_rst_reg) begin
      for (i = 0; i < `MCI_NPAR; i = i + 1) begin
        pend_reg[i] <= nv_valid_reg ? nv_reg[i] : par_default(i[2:0], 1'b0);
        act_reg[i] <= nv_valid_reg ? nv_reg[i] : par_default(i[2:0], 1'b0);
      end
      ok_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (wr_bad) begin
        ok_reg <= 1'b0;
        err_reg <= 1'b1;
      end else if (wr && is_par) begin
        pend_reg[pidx_full[2:0]] <= wr_val;
        ok_reg <= 1'b1;
        err_reg <= 1'b0;
      end else if (cmd_go) begin
        ok_reg <= 1'b1;
        err_reg <= 1'b0;
        case (cmd)
          `MCI_C_PERSIST: begin
            for (i = 0; i < `MCI_NPAR; i = i + 1) begin
              nv_reg[i] <= pend_reg[i];
            end
            nv_valid_reg <= 1'b1;
          end
          `MCI_C_FACTORY, `MCI_C_BUILD: begin
            for (i = 0; i < `MCI_NPAR; i = i + 1) begin
              pend_reg[i] <= par_default(i[2:0], cmd == `MCI_C_BUILD);
              act_reg[i] <= par_default(i[2:0], cmd == `MCI_C_BUILD);
            end
          end
          `MCI_C_COMMIT: begin
            for (i = 0; i < `MCI_NPAR; i = i + 1) begin
              act_reg[i] <= pend_reg[i];
            end
          end
          `MCI_C_VERSION: begin
            ver_date_reg <= BUILD_DATE;
            ver_time_reg <= BUILD_TIME;
          end
          default: begin
            ok_reg <= 1'b1; // Restart answers OK at once
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Restart delay
  // ----------------------------------------
  // One restart at a time: commands refused meanwhile
  mci_delay_timer #(
    .LEN(RESTART_CYCLES)
  ) u_restart (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(cmd_go && cmd == `MCI_C_RESTART),
    .busy_reg(restart_busy),
    .done_reg(restart_done)
  );

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_rst_reg <= 1'b0;
      module_reset <= 1'b0;
    end else begin
      soft_rst_reg <= restart_done;
      module_reset <= restart_done;
    end
  end

  // ----------------------------------------
  // Sleep diagnostics
  // ----------------------------------------
  mci_missed_sync u_missed (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .soft_clr(soft_rst_reg),
    .cycle_done(sleep_cycle_done),
    .sync_rx(sync_rx),
    .count_reg(missed_count)
  );

  // Frames follow committed settings only
  wire framed = (act_reg[`MCI_P_PROTO] == `MCI_PROTO_FRAMED);
  wire notify = act_reg[`MCI_P_SLPOPT][`MCI_SOPT_NOTIFY] && framed;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_frame_valid <= 1'b0;
      status_frame_code <= 8'h00;
    end else begin
      status_frame_valid <= notify && (woke_evt || sleep_evt);
      if (notify && woke_evt) begin
        status_frame_code <= `MCI_FR_WAKE;
      end else if (notify && sleep_evt) begin
        status_frame_code <= `MCI_FR_SLEEP;
      end
    end
  end

  // ----------------------------------------
  // Transmit fields and payload limit
  // ----------------------------------------
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_dest_addr <= {`MCI_DEF_DESTHI, `MCI_DEF_DESTLO};
      tx_source_endpoint <= 8'h00;
      tx_target_endpoint <= 8'h00;
      tx_cluster_ident <= 16'h0000;
      channel_select <= 3'h0;
      framed_host_protocol <= 1'b0;
      max_pay_reg <= `MCI_PAY_BASE;
    end else begin
      // Pending writes wait for commit
      tx_dest_addr <= {act_reg[`MCI_P_DESTHI], act_reg[`MCI_P_DESTLO]};
      tx_source_endpoint <= act_reg[`MCI_P_SRCEP][7:0];
      tx_target_endpoint <= act_reg[`MCI_P_DSTEP][7:0];
      tx_cluster_ident <= act_reg[`MCI_P_CLUSTER][15:0];
      channel_select <= act_reg[`MCI_P_CHAN][2:0];
      framed_host_protocol <= framed;
      // Broadcast destinations and framing both cost payload room
      max_pay_reg <= `MCI_PAY_BASE
        - ((act_reg[`MCI_P_DESTLO] == `MCI_DEF_DESTLO) ? `MCI_PAY_BCAST : 16'h0000)
        - (framed ? `MCI_PAY_FRAMED : 16'h0000);
    end
  end

endmodule // mci_top

// ### tb/mci_top_asserts.sv
/*
  Checker of mci_top port behaviour: bus answers, refusals, frames, restart, defaults.
  Assumes INTL_VARIANT at 0 and full byte enables on writes.
*/
`timescale 1ns/10ps
module mci_top_asserts #(
  parameter RESTART_CYCLES = 20
) (
  input wire sys_clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire [63:0] tx_dest_addr,
  input wire [7:0] tx_source_endpoint,
  input wire [7:0] tx_target_endpoint,
  input wire [15:0] tx_cluster_ident,
  input wire [2:0] channel_select,
  input wire framed_host_protocol,
  input wire status_frame_valid,
  input wire [7:0] status_frame_code,
  input wire woke_evt,
  input wire sleep_evt,
  input wire module_reset
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  localparam int RLO = RESTART_CYCLES;
  localparam int RHI = RESTART_CYCLES + 1;
  reg [3:0] quiet_reg;
  wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire wr = taken && wb_we_i;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Parameter writes only reach pending, so outputs may move only after a command
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      quiet_reg <= 4'h0;
    else if ((wr && wb_adr_i == 8'h00) || module_reset)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF)
      quiet_reg <= quiet_reg + 4'h1;
  end
  sequence restart_ok;
    wr && wb_adr_i == 8'h00 && wb_dat_i[7:0] == 8'h03 ##1 wb_ack_o;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_bus_answer: assert property (taken |=> wb_ack_o != wb_err_o)
    else $error("request not answered by exactly one of ack and err");
  a_chan_refused: assert property (wr && wb_adr_i == 8'h0C && wb_dat_i > 32'h0000_0007 |=> wb_err_o)
    else $error("channel above limit accepted");
  a_readonly_refused: assert property (wr && wb_adr_i >= 8'h24 && wb_adr_i <= 8'h48
    && wb_adr_i[1:0] == 2'b00 |=> wb_err_o)
    else $error("write to read-only place accepted");
  a_frame_cause: assert property (status_frame_valid |-> $past(woke_evt || sleep_evt) && framed_host_protocol)
    else $error("status frame without event or outside framed mode");
  a_frame_code: assert property (status_frame_valid |-> status_frame_code == ($past(woke_evt) ? 8'h0B : 8'h0C))
    else $error("status frame code does not match event");
  a_restart_late: assert property (restart_ok |-> ##[RLO:RHI] module_reset)
    else $error("module reset not issued at end of restart delay");
  a_restart_early: assert property (restart_ok |-> !module_reset [*8])
    else $error("module reset issued before restart delay");
  a_reset_defaults: assert property ($rose(arst_n) |-> tx_dest_addr == 64'h0000_0000_0000_FFFF
    ##1 tx_cluster_ident == 16'h0011 && channel_select == 3'h0)
    else $error("defaults not present after reset");
  a_outputs_hold: assert property (quiet_reg >= 4'h3 |-> $stable(tx_dest_addr) && $stable(tx_cluster_ident)
    && $stable(tx_source_endpoint) && $stable(tx_target_endpoint) && $stable(channel_select))
    else $error("transmit fields changed without a command");
endmodule // mci_top_asserts

bind mci_top mci_top_asserts #(.RESTART_CYCLES(RESTART_CYCLES)) u_mci_chk (
  .sys_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_err_o,
  .tx_dest_addr, .tx_source_endpoint, .tx_target_endpoint, .tx_cluster_ident, .channel_select,
  .framed_host_protocol, .status_frame_valid, .status_frame_code, .woke_evt, .sleep_evt, .module_reset
);

// ### tb/mci_sleep_sched.sv
/*
  Sleep scheduler stand-in: operational periods, status and one-cycle events.
  Assumes one-cycle request pulses from the bench on sys_clk.
*/
`timescale 1ns/10ps
module mci_sleep_sched #(
  parameter [31:0] SLEEP_P = 32'h0000_1388,
  parameter [31:0] WAKE_P = 32'h0000_07D0,
  parameter GAP = 3
) (
  input wire sys_clk,
  input wire arst_n,
  input wire cycle_req,
  input wire sync_req,
  output wire [31:0] op_sleep_period,
  output wire [31:0] op_wake_period,
  output reg [7:0] sleep_status_bits,
  output reg is_sleep_coord,
  output reg sleep_cycle_done,
  output reg sync_rx,
  output reg woke_evt,
  output reg sleep_evt
);
  reg [7:0] ph_reg;
  assign op_sleep_period = SLEEP_P;
  assign op_wake_period = WAKE_P;
  // GAP sets how slowly one sleep cycle runs: enter sleep, cycle end, wake
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg <= 8'h00;
      sleep_status_bits <= 8'h00;
      is_sleep_coord <= 1'b0;
      {sleep_evt, sleep_cycle_done, woke_evt, sync_rx} <= 4'h0;
    end else begin
      sync_rx <= sync_req;
      sleep_evt <= (ph_reg == 8'h01);
      sleep_cycle_done <= (ph_reg == 8'(1 + GAP));
      woke_evt <= (ph_reg == 8'(1 + 2 * GAP));
      if (cycle_req && ph_reg == 8'h00)
        ph_reg <= 8'h01;
      else if (ph_reg != 8'h00)
        ph_reg <= (ph_reg == 8'(2 + 2 * GAP)) ? 8'h00 : ph_reg + 8'h01;
      if (sleep_cycle_done) begin
        sleep_status_bits <= sleep_status_bits + 8'h01;
        is_sleep_coord <= ~is_sleep_coord;
      end
    end
  end
endmodule // mci_sleep_sched

// ### tb/test_module_command_interpreter.sv
/*
  Bench for mci_top: random and corner register traffic over classic Wishbone.
  Assumes the checker is bound by its own file and the scheduler model drives events.
*/
`timescale 1ns/10ps
module test_module_command_interpreter;
  localparam [31:0] DEVT = 32'h0000_5A31; // Arbitrary value
  localparam [31:0] UIDH = 32'h0000_0777; // Arbitrary value
  localparam [31:0] UIDL = 32'h0000_4242; // Arbitrary value
  localparam [31:0] BDATE = 32'h0000_0314; // Arbitrary value
  localparam [31:0] BTIME = 32'h0000_0930; // Arbitrary value
  logic sys_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic cycle_req = 1'b0, sync_req = 1'b0, e;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, q, r1, r2;
  logic [15:0] lfsr = 16'h004D;
  int n_fail = 0, tests_run = 0, n_frames = 0;
  wire [31:0] wb_dat_o, op_sleep_period, op_wake_period;
  wire wb_ack_o, wb_err_o, is_sleep_coord, sleep_cycle_done, sync_rx, woke_evt, sleep_evt;
  wire framed_host_protocol, status_frame_valid, module_reset;
  wire [7:0] sleep_status_bits, status_frame_code, tx_source_endpoint, tx_target_endpoint;
  wire [63:0] tx_dest_addr;
  wire [15:0] tx_cluster_ident;
  wire [2:0] channel_select;

  mci_top #(.RESTART_CYCLES(20), .DEVICE_TYPE(DEVT), .UID_UPPER(UIDH), .UID_LOWER(UIDL),
    .BUILD_DATE(BDATE), .BUILD_TIME(BTIME)) dut (
    .sys_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .op_sleep_period, .op_wake_period, .sleep_status_bits,
    .is_sleep_coord, .sleep_cycle_done, .sync_rx, .woke_evt, .sleep_evt, .tx_dest_addr,
    .tx_source_endpoint, .tx_target_endpoint, .tx_cluster_ident, .channel_select,
    .framed_host_protocol, .status_frame_valid, .status_frame_code, .module_reset);
  mci_sleep_sched #(.GAP(3)) sched (.sys_clk, .arst_n, .cycle_req, .sync_req, .op_sleep_period,
    .op_wake_period, .sleep_status_bits, .is_sleep_coord, .sleep_cycle_done, .sync_rx, .woke_evt, .sleep_evt);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (status_frame_valid === 1'b1)
      n_frames <= n_frames + 1;
  end
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] pay(input logic [31:0] lo, input logic fr);
    return 32'h0000_0100 - (lo == 32'h0000_FFFF ? 32'h8 : 32'h0) - (fr ? 32'h2 : 32'h0);
  endfunction
  task automatic rnd(output logic [31:0] r);
    lfsr = step(lfsr);
    r[31:16] = lfsr;
    lfsr = step(lfsr);
    r[15:0] = lfsr;
  endtask
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Holds the request until ack or err is seen, so nothing new goes out before the answer
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, 1'b1, w, a, d};
    do
      @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    wb(1'b1, a, d);
    chk($sformatf("refusal_%h", a), 64'(e), 64'(x));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0000_0000);
    chk($sformatf("read_%h", a), 64'(q), 64'(x));
  endtask
  task automatic slp_cycle();
    @(posedge sys_clk) cycle_req <= 1'b1;
    @(posedge sys_clk) cycle_req <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int n;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("dest", tx_dest_addr, 64'h0000_0000_0000_FFFF);
    chk("cluster", 64'(tx_cluster_ident), 64'h11);
    for (int i = 0; i < 3; i++) begin
      rnd(r1);
      wr(8'h24 + 8'(4 * i), r1, 1'b1);
    end
    rd(8'h24, DEVT);
    rd(8'h28, UIDH);
    rd(8'h2C, UIDL);
    for (int c = 0; c < 10; c++)
      wr(8'h0C, 32'(c), 1'(c > 7));
    rd(8'h0C, 32'h0000_0007);
    wr(8'h10, 32'h0000_0100, 1'b1);
    wr(8'h18, 32'h0001_0000, 1'b1);
    wr(8'h1C, 32'h0000_0003, 1'b1);
    repeat (4) begin
      rnd(r1);
      rnd(r2);
      wr(8'h04, r1, 1'b0);
      wr(8'h08, r2, 1'b0);
      wr(8'h10, {24'h0, r1[7:0]}, 1'b0);
      wr(8'h14, {24'h0, r2[7:0]}, 1'b0);
      wr(8'h18, {16'h0, r2[31:16]}, 1'b0);
      wr(8'h00, 32'h0000_0004, 1'b0);
      @(negedge sys_clk);
      chk("dest", tx_dest_addr, {r1, r2});
      chk("src_ep", 64'(tx_source_endpoint), 64'(r1[7:0]));
      chk("tgt_ep", 64'(tx_target_endpoint), 64'(r2[7:0]));
      chk("cluster", 64'(tx_cluster_ident), 64'(r2[31:16]));
      rd(8'h30, pay(r2, 1'b0));
    end
    wr(8'h08, 32'h0000_FFFF, 1'b0);
    wr(8'h1C, 32'h0000_0001, 1'b0);
    wr(8'h20, 32'h0000_0001, 1'b0);
    slp_cycle();
    chk("frames", 64'(n_frames), 64'h0);
    wr(8'h00, 32'h0000_0004, 1'b0);
    rd(8'h30, pay(32'h0000_FFFF, 1'b1));
    chk("framed", 64'(framed_host_protocol), 64'h1);
    slp_cycle();
    slp_cycle();
    chk("frames", 64'(n_frames), 64'h4);
    rd(8'h40, 32'h0000_0003);
    rd(8'h34, 32'h0000_1388);
    rd(8'h38, 32'h0000_07D0);
    rd(8'h3C, {23'h0, 1'b1, 8'h03});
    @(posedge sys_clk) sync_req <= 1'b1;
    @(posedge sys_clk) sync_req <= 1'b0;
    rd(8'h40, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0005, 1'b0);
    wr(8'h00, 32'h0000_0001, 1'b0);
    wr(8'h00, 32'h0000_0002, 1'b0);
    @(negedge sys_clk);
    chk("dest", tx_dest_addr, 64'h0000_0000_0000_FFFF);
    chk("cluster", 64'(tx_cluster_ident), 64'h11);
    rd(8'h0C, 32'h0000_0000);
    wb_sel_i <= 4'h1;
    wr(8'h18, 32'hFFFF_FF22, 1'b0);
    wb_sel_i <= 4'hF;
    rd(8'h18, 32'h0000_0022);
    wr(8'h00, 32'h0000_0003, 1'b0);
    rd(8'h00, 32'h0000_000D);
    wr(8'h00, 32'h0000_0004, 1'b1);
    n = 0;
    while (module_reset !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk("restart", 64'(module_reset), 64'h1);
    repeat (3) @(negedge sys_clk);
    chk("chan", 64'(channel_select), 64'h5);
    wr(8'h00, 32'h0000_0005, 1'b0);
    @(negedge sys_clk);
    chk("chan", 64'(channel_select), 64'h0);
    wr(8'h00, 32'h0000_0006, 1'b0);
    rd(8'h44, BDATE);
    rd(8'h48, BTIME);
    wr(8'h00, 32'h0000_0007, 1'b1);
    rd(8'h80, 32'h0000_0000);
    print_verdict();
  end
endmodule // test_module_command_interpreter
